// ### hw/alarm_pkg.sv
// constants, register map and decode helpers for the alarm control block
package alarm_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [6:0]  CONFIG_ONE_ADDR    = 7'h4D;
    localparam logic [6:0]  ALARM_CONTROL_ADDR = 7'h4E;
    localparam logic [6:0]  STATUS_ADDR        = 7'h4F;

    localparam logic [15:0] CONFIG_ONE_RESET    = 16'h0070;
    localparam logic [15:0] ALARM_CONTROL_RESET = 16'h0000;

    // writable bits of each configuration register; everything else reads zero
    localparam logic [15:0] CONFIG_ONE_MASK    = 16'h03F8;
    localparam logic [15:0] ALARM_CONTROL_MASK = 16'h7FFC;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int RATE_LSB        = 8;
    localparam int INPUT_COUNT_LSB = 5;
    localparam int TEMP_COUNT_LSB  = 3;
    localparam int ENABLE_MSB      = 14;
    localparam int ENABLE_LSB      = 3;
    localparam int HOLD_DISABLE    = 2;
    localparam int THERMAL_FLAG    = 2;

    localparam int NUM_INPUTS  = 4;
    localparam int NUM_TEMPS   = 3;
    localparam int NUM_FILTER  = NUM_INPUTS + 2 * NUM_TEMPS;
    localparam int NUM_FLAGS   = NUM_FILTER + 2;
    localparam int COUNT_WIDTH = 9;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ        = 200_000_000;
    localparam int BASE_RATE_SPS = 500_000;
    localparam int BASE_CYCLES   = CLK_HZ / BASE_RATE_SPS;
    localparam int TICK_WIDTH    = 12;

    // consecutive-sample count for the analog inputs
    function automatic logic [COUNT_WIDTH-1:0] inputCount(input logic [2:0] code);
        inputCount = (code == 3'h0) ? 9'h001 : 9'(9'h002 << code);
    endfunction

    // consecutive-sample count for the temperature sensors
    function automatic logic [COUNT_WIDTH-1:0] tempCount(input logic [1:0] code);
        tempCount = 9'(9'h001 << code);
    endfunction

endpackage

// ### hw/consecutive_filter.sv
// counts consecutive out-of-range samples and raises a condition at the limit
module consecutive_filter #(
    parameter int WIDTH = 9
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // sample stream
    input  wire logic             sampleDone,
    input  wire logic             outOfRange,
    input  wire logic [WIDTH-1:0] limit,
    // filtered condition
    output logic                  condition
);

    logic [WIDTH-1:0] run_q;
    logic [WIDTH-1:0] run_d;

    // saturate at the limit so a long fault never wraps back to zero
    always_comb begin
        run_d = run_q;
        if (sampleDone) begin
            if (!outOfRange) begin
                run_d = '0;
            end else if (run_q < limit) begin
                run_d = WIDTH'(run_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= '0;
        end else begin
            run_q <= run_d;
        end
    end

    // a limit lowered mid-run takes effect at once
    assign condition = (run_q != '0) && (run_q >= limit);

endmodule

// ### hw/alarm_filter_and_mask_control.sv
// alarm filtering, masking, flag holding and alarm pin control
module alarm_filter_and_mask_control
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // register port from the serial host decoder
    input  wire logic [6:0]            regAddr,
    input  wire logic [15:0]           regWrData,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic [15:0]                regRdData,
    output logic                       regRdValid,
    // comparator results, one strobe per compared sample
    input  wire logic [alarm_pkg::NUM_INPUTS-1:0] inputSampleDone,
    input  wire logic [alarm_pkg::NUM_INPUTS-1:0] inputOutOfRange,
    input  wire logic [alarm_pkg::NUM_TEMPS-1:0]  tempSampleDone,
    input  wire logic [alarm_pkg::NUM_TEMPS-1:0]  tempUnder,
    input  wire logic [alarm_pkg::NUM_TEMPS-1:0]  tempOver,
    input  wire logic [1:0]            remoteFailure,
    input  wire logic                  thermalCondition,
    // pin enable from the other configuration register
    input  wire logic                  alarmPinEnable,
    // converter pacing
    output logic [1:0]                 sampleRateSelect,
    output logic                       sampleTick,
    // alarm outputs
    output logic [15:0]                statusFlags,
    output logic                       globalFlag,
    output logic                       alarmN
);
    import alarm_pkg::*;

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [15:0] configOne_q;
    logic [15:0] configOne_d;
    logic [15:0] alarmControl_q;
    logic [15:0] alarmControl_d;

    // only documented fields are writable, reserved bits stay zero
    always_comb begin
        configOne_d    = configOne_q;
        alarmControl_d = alarmControl_q;
        if (regWrite && regAddr == CONFIG_ONE_ADDR) begin
            configOne_d = regWrData & CONFIG_ONE_MASK;
        end
        if (regWrite && regAddr == ALARM_CONTROL_ADDR) begin
            alarmControl_d = regWrData & ALARM_CONTROL_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            configOne_q    <= CONFIG_ONE_RESET;
            alarmControl_q <= ALARM_CONTROL_RESET;
        end else begin
            configOne_q    <= configOne_d;
            alarmControl_q <= alarmControl_d;
        end
    end

    logic [1:0]             rateCode;
    logic [2:0]             inputCode;
    logic [1:0]             tempCode;
    logic [COUNT_WIDTH-1:0] inputLimit;
    logic [COUNT_WIDTH-1:0] tempLimit;
    logic                   holdDisable;
    logic [11:0]            alarmEnable;

    // field extraction and count decode
    assign rateCode    = configOne_q[RATE_LSB+1:RATE_LSB];
    assign inputCode   = configOne_q[INPUT_COUNT_LSB+2:INPUT_COUNT_LSB];
    assign tempCode    = configOne_q[TEMP_COUNT_LSB+1:TEMP_COUNT_LSB];
    assign inputLimit  = inputCount(inputCode);
    assign tempLimit   = tempCount(tempCode);
    assign holdDisable = alarmControl_q[HOLD_DISABLE];
    assign alarmEnable = alarmControl_q[ENABLE_MSB:ENABLE_LSB];
    assign sampleRateSelect = rateCode;

    // ************************************************************
    // sample pacing
    // ************************************************************
    logic [TICK_WIDTH-1:0] tick_q;
    logic [TICK_WIDTH-1:0] tick_d;
    logic                  tickOut_q;
    logic                  tickOut_d;
    logic [TICK_WIDTH-1:0] period;

    // each rate step doubles the period of the 500 kSPS base
    assign period = TICK_WIDTH'(BASE_CYCLES) << rateCode;

    always_comb begin
        tickOut_d = 1'b0;
        tick_d    = TICK_WIDTH'(tick_q + 1'b1);
        if (tick_q >= TICK_WIDTH'(period - 1'b1)) begin
            tick_d    = '0;
            tickOut_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_q    <= '0;
            tickOut_q <= 1'b0;
        end else begin
            tick_q    <= tick_d;
            tickOut_q <= tickOut_d;
        end
    end

    assign sampleTick = tickOut_q;

    // ************************************************************
    // consecutive-sample filters
    // ************************************************************
    logic [NUM_FILTER-1:0]  filtDone;
    logic [NUM_FILTER-1:0]  filtBad;
    logic [NUM_FILTER-1:0]  filtCond;
    logic [NUM_FLAGS-1:0]   condition;

    // filter slots: inputs 0..3, then each sensor's under and over
    always_comb begin
        filtDone = '0;
        filtBad  = '0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            filtDone[i] = inputSampleDone[i];
            filtBad[i]  = inputOutOfRange[i];
        end
        for (int t = 0; t < NUM_TEMPS; t++) begin
            filtDone[NUM_INPUTS+2*t]   = tempSampleDone[t];
            filtBad[NUM_INPUTS+2*t]    = tempUnder[t];
            filtDone[NUM_INPUTS+2*t+1] = tempSampleDone[t];
            filtBad[NUM_INPUTS+2*t+1]  = tempOver[t];
        end
    end

    for (genvar g = 0; g < NUM_FILTER; g++) begin : gen_filter
        consecutive_filter #(
            .WIDTH      (COUNT_WIDTH)
        ) u_filter (
            .clk        (clk),
            .rst        (rst),
            .sampleDone (filtDone[g]),
            .outOfRange (filtBad[g]),
            .limit      ((g < NUM_INPUTS) ? inputLimit : tempLimit),
            .condition  (filtCond[g])
        );
    end

    // flag order matches status bits 14 down to 3: inputs, sensors, failures
    always_comb begin
        condition = '0;
        for (int k = 0; k < NUM_FILTER; k++) begin
            condition[NUM_FLAGS-1-k] = filtCond[k];
        end
        condition[1] = remoteFailure[0];
        condition[0] = remoteFailure[1];
    end

    // ************************************************************
    // status flags and global flag
    // ************************************************************
    logic [NUM_FLAGS-1:0] flag_q;
    logic [NUM_FLAGS-1:0] flag_d;
    logic [NUM_FLAGS-1:0] seenRead_q;
    logic [NUM_FLAGS-1:0] seenRead_d;
    logic                 thermFlag_q;
    logic                 thermFlag_d;
    logic                 thermRead_q;
    logic                 thermRead_d;
    logic                 global_q;
    logic                 global_d;
    logic                 statusRead;

    assign statusRead = regRead && (regAddr == STATUS_ADDR);

    // a set always wins over a clear in the same cycle
    always_comb begin
        flag_d     = flag_q;
        seenRead_d = seenRead_q;
        for (int k = 0; k < NUM_FLAGS; k++) begin
            if (holdDisable) begin
                flag_d[k]     = condition[k];
                seenRead_d[k] = 1'b0;
            end else if (condition[k]) begin
                flag_d[k]     = 1'b1;
                seenRead_d[k] = seenRead_q[k] | (statusRead & flag_q[k]);
            end else if (flag_q[k] && (statusRead || seenRead_q[k])) begin
                flag_d[k]     = 1'b0;
                seenRead_d[k] = 1'b0;
            end
        end
        thermFlag_d = thermFlag_q;
        thermRead_d = thermRead_q;
        if (holdDisable) begin
            thermFlag_d = thermalCondition;
            thermRead_d = 1'b0;
        end else if (thermalCondition) begin
            thermFlag_d = 1'b1;
            thermRead_d = thermRead_q | (statusRead & thermFlag_q);
        end else if (thermFlag_q && (statusRead || thermRead_q)) begin
            thermFlag_d = 1'b0;
            thermRead_d = 1'b0;
        end
        // a flag still standing after the read keeps the global flag up
        global_d = (|flag_d) | thermFlag_d | (global_q & ~statusRead);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q      <= '0;
            seenRead_q  <= '0;
            thermFlag_q <= 1'b0;
            thermRead_q <= 1'b0;
            global_q    <= 1'b0;
        end else begin
            flag_q      <= flag_d;
            seenRead_q  <= seenRead_d;
            thermFlag_q <= thermFlag_d;
            thermRead_q <= thermRead_d;
            global_q    <= global_d;
        end
    end

    assign statusFlags = {1'b0, flag_q, thermFlag_q, 2'b00};
    assign globalFlag  = global_q;

    // ************************************************************
    // alarm pin
    // ************************************************************
    logic pinLow_q;
    logic pinLow_d;

    // thermal flag has no enable bit and never reaches the pin
    always_comb begin
        pinLow_d = alarmPinEnable && (|(flag_q & alarmEnable));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinLow_q <= 1'b0;
        end else begin
            pinLow_q <= pinLow_d;
        end
    end

    assign alarmN = ~pinLow_q;

    // ************************************************************
    // register read port
    // ************************************************************
    logic [15:0] rdData_q;
    logic [15:0] rdData_d;
    logic        rdValid_q;

    // unmapped addresses read zero; the status read returns pre-clear flags
    always_comb begin
        case (regAddr)
            CONFIG_ONE_ADDR:    rdData_d = configOne_q;
            ALARM_CONTROL_ADDR: rdData_d = alarmControl_q;
            STATUS_ADDR:        rdData_d = statusFlags;
            default:            rdData_d = 16'h0000;
        endcase
        if (!regRead) begin
            rdData_d = rdData_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= regRead;
        end
    end

    assign regRdData  = rdData_q;
    assign regRdValid = rdValid_q;

endmodule

// ### sim/host_model.sv
// host controller model driving the parallel register port
module host_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic [6:0]       regAddr,
    output logic [15:0]      regWrData,
    output logic             regWrite,
    output logic             regRead,
    input  wire logic [15:0] regRdData,
    input  wire logic        regRdValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port from time zero, nothing requested during reset
    initial begin
        regAddr   = 7'h00;
        regWrData = 16'h0000;
        regWrite  = 1'b0;
        regRead   = 1'b0;
    end

    // one write; data inverted once released so stale data never looks valid
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
        regWrData <= ~d;
    endtask

    // one read; data taken at the rising edge where the valid pulse is sampled high
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        int n;
        d = 16'hDEAD;
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (regRdValid === 1'b1) begin
                d = regRdData;
                break;
            end
        end
    endtask
endmodule

// ### sim/alarm_filter_and_mask_control_assertions.sv
// port-level assertions for the alarm control block
module alarm_filter_and_mask_control_assertions
    import alarm_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register port
    input wire logic [6:0]  regAddr,
    input wire logic        regRead,
    input wire logic [15:0] regRdData,
    input wire logic        regRdValid,
    // pacing and sources
    input wire logic [1:0]  sampleRateSelect,
    input wire logic        sampleTick,
    input wire logic [1:0]  remoteFailure,
    input wire logic        alarmPinEnable,
    // alarm outputs
    input wire logic [15:0] statusFlags,
    input wire logic        globalFlag,
    input wire logic        alarmN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    logic [11:0] gap_q;
    logic        gapOk_q;

    // cycles since last tick; an interval spanning a rate change is not judged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q   <= 12'h000;
            gapOk_q <= 1'b0;
        end else begin
            gap_q   <= sampleTick ? 12'h000 : gap_q + 12'h001;
            gapOk_q <= (sampleTick | gapOk_q) & $stable(sampleRateSelect);
        end
    end

    read_valid_a : assert property (regRdValid == $past(regRead))
        else $error("read valid not one cycle after read");
    ctrl_reserved_a : assert property (
        regRdValid && $past(regAddr) == ALARM_CONTROL_ADDR |-> regRdData[15] == 1'b0 && regRdData[1:0] == 2'b00)
        else $error("alarm control reserved bits nonzero");
    tick_gap_a : assert property (sampleTick && gapOk_q |-> gap_q == (12'd400 << sampleRateSelect) - 12'd1)
        else $error("sample tick spacing wrong");
    pin_gate_a : assert property (!alarmPinEnable [*2] |-> alarmN)
        else $error("alarm pin low while disabled");
    pin_release_a : assert property ((statusFlags & 16'h7FF8) == 16'h0000 |=> alarmN)
        else $error("alarm pin low without a flag");
    global_set_a : assert property ((|statusFlags) && !regRead |-> ##[0:1] globalFlag)
        else $error("global flag missing");
    global_clear_a : assert property ($fell(globalFlag) |-> $past(regRead) && $past(regAddr) == STATUS_ADDR)
        else $error("global flag cleared without status read");
    fail_flag_a : assert property (remoteFailure[0] |-> ##[1:2] statusFlags[4])
        else $error("failure flag not set");

    // main scenarios reached
    cover property (!alarmN);
    cover property ($fell(globalFlag));
    cover property (sampleTick && sampleRateSelect == 2'b11);
endmodule

bind alarm_filter_and_mask_control alarm_filter_and_mask_control_assertions u_alarm_filter_and_mask_control_assertions (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
    .sampleRateSelect(sampleRateSelect), .sampleTick(sampleTick), .remoteFailure(remoteFailure),
    .alarmPinEnable(alarmPinEnable), .statusFlags(statusFlags), .globalFlag(globalFlag), .alarmN(alarmN));

// ### sim/alarm_filter_and_mask_control_tb_top.sv
// self-checking bench for the alarm filter and mask control block
module alarm_filter_and_mask_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import alarm_pkg::*;

    logic        clk, rst, regWrite, regRead, regRdValid, pinEn, tick, glob, alarmN;
    logic [6:0]  regAddr;
    logic [15:0] regWrData, regRdData, flags, rd;
    logic [3:0]  inDone, inOor;
    logic [2:0]  tDone, tUnder, tOver;
    logic [1:0]  remFail, rate;
    int          fails = 0, testsRun = 0, cycles = 0;

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    host_model u_host_model (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid));

    // thermal input tied off: it feeds status bit 2 and the global flag; the thermal path is outside this plan
    alarm_filter_and_mask_control u_alarm_filter_and_mask_control (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid), .inputSampleDone(inDone), .inputOutOfRange(inOor), .tempSampleDone(tDone),
        .tempUnder(tUnder), .tempOver(tOver), .remoteFailure(remFail), .thermalCondition(1'b0),
        .alarmPinEnable(pinEn), .sampleRateSelect(rate), .sampleTick(tick), .statusFlags(flags),
        .globalFlag(glob), .alarmN(alarmN));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one sample or failure level for the source behind status bit b; waits out flag and pin
    task automatic src(input int b, input logic v);
        @(posedge clk);
        if (b > 10) begin
            inOor[14-b]  <= v;
            inDone[14-b] <= 1'b1;
        end else if (b > 4) begin
            if (b % 2 == 0) tUnder[(10-b)/2] <= v;
            else tOver[(10-b)/2] <= v;
            tDone[(10-b)/2] <= 1'b1;
        end else begin
            remFail[4-b] <= v;
        end
        @(posedge clk);
        inDone <= '0;
        tDone  <= '0;
        repeat (5) @(negedge clk);
    endtask

    task automatic testRegs();
        u_host_model.rd(CONFIG_ONE_ADDR, rd);
        chk("config one reset", 16'h0070, rd);
        u_host_model.rd(ALARM_CONTROL_ADDR, rd);
        chk("alarm control reset", 16'h0000, rd);
        u_host_model.wr(ALARM_CONTROL_ADDR, 16'hFFFF);
        u_host_model.rd(ALARM_CONTROL_ADDR, rd);
        chk("alarm control bits", 16'h7FFC, rd);
        u_host_model.wr(CONFIG_ONE_ADDR, 16'hFFFF);
        u_host_model.rd(CONFIG_ONE_ADDR, rd);
        chk("config one bits", 16'h03F8, rd);
        u_host_model.wr(STATUS_ADDR, 16'hFFFF);
        u_host_model.rd(STATUS_ADDR, rd);
        chk("status write ignored", 16'h0000, rd);
        u_host_model.rd(7'h10, rd);
        chk("unmapped read", 16'h0000, rd);
        $display("registers done");
    endtask

    // gap between two ticks at each rate code
    task automatic testRate();
        int r, n;
        for (r = 0; r < 4; r++) begin
            u_host_model.wr(CONFIG_ONE_ADDR, 16'(r << 8));
            repeat (2) begin
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (tick !== 1'b1 && n < 8000);
            end
            chk("tick gap", 16'(400 << r), 16'(n));
            chk("rate field", 16'(r), 16'(rate));
        end
        $display("rate done");
    endtask

    // every count code of inputs and sensors, one sample short then exact
    task automatic testCount();
        int k, n, b, i;
        u_host_model.wr(ALARM_CONTROL_ADDR, 16'h0004);
        for (k = 0; k < 12; k++) begin
            b = k < 8 ? 13 : 7;
            n = k < 8 ? (k == 0 ? 1 : 2 << k) : 1 << (k - 8);
            u_host_model.wr(CONFIG_ONE_ADDR, k < 8 ? 16'(k << 5) : 16'((k - 8) << 3));
            for (i = 1; i < n; i++) src(b, 1'b1);
            chk("flag below count", 16'h0000, 16'(flags[b]));
            src(b, 1'b1);
            chk("flag at count", 16'h0001, 16'(flags[b]));
            src(b, 1'b0);
        end
        u_host_model.rd(STATUS_ADDR, rd);
        $display("counts done");
    endtask

    task automatic testHold();
        u_host_model.wr(ALARM_CONTROL_ADDR, 16'h0000);
        u_host_model.wr(CONFIG_ONE_ADDR, 16'h0000);
        src(14, 1'b1);
        chk("masked flag", 16'h4000, flags);
        chk("masked pin", 16'h0001, 16'(alarmN));
        u_host_model.wr(ALARM_CONTROL_ADDR, 16'h4000);
        repeat (3) @(negedge clk);
        chk("enabled pin", 16'h0000, 16'(alarmN));
        @(posedge clk);
        pinEn <= 1'b0;
        repeat (3) @(negedge clk);
        chk("pin disabled", 16'h0001, 16'(alarmN));
        @(posedge clk);
        pinEn <= 1'b1;
        src(14, 1'b0);
        chk("held flag", 16'h4000, flags);
        chk("pin held", 16'h0000, 16'(alarmN));
        chk("global set", 16'h0001, 16'(glob));
        u_host_model.rd(STATUS_ADDR, rd);
        chk("status read", 16'h4000, rd);
        repeat (2) @(negedge clk);
        chk("flags cleared", 16'h0000, flags);
        chk("global cleared", 16'h0000, 16'(glob));
        chk("pin released", 16'h0001, 16'(alarmN));
        src(12, 1'b1);
        u_host_model.rd(STATUS_ADDR, rd);
        chk("status during fault", 16'h1000, rd);
        src(12, 1'b0);
        chk("read before end", 16'h0000, flags);
        u_host_model.rd(STATUS_ADDR, rd);
        @(negedge clk);
        chk("global read clear", 16'h0000, 16'(glob));
        u_host_model.wr(ALARM_CONTROL_ADDR, 16'h0004);
        src(11, 1'b1);
        chk("follow set", 16'h0800, flags);
        src(11, 1'b0);
        chk("follow flag", 16'h0000, flags);
        chk("global kept", 16'h0001, 16'(glob));
        u_host_model.rd(STATUS_ADDR, rd);
        $display("hold done");
    endtask

    // each enable bit alone pulls the pin; masking it alone releases the pin but keeps the flag
    task automatic testPin();
        int b;
        for (b = 14; b > 2; b--) begin
            u_host_model.wr(ALARM_CONTROL_ADDR, 16'(1 << b) | 16'h0004);
            src(b, 1'b1);
            chk("source pin", 16'h0000, 16'(alarmN));
            u_host_model.wr(ALARM_CONTROL_ADDR, ~16'(1 << b) & 16'h7FF8);
            repeat (3) @(negedge clk);
            chk("masked pin", 16'h0001, 16'(alarmN));
            chk("masked flag", 16'h0001, 16'(flags[b]));
            src(b, 1'b0);
            u_host_model.rd(STATUS_ADDR, rd);
        end
        $display("pin done");
    endtask

    task automatic endSim();
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole run needs some 15600 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            endSim();
        end
    end

    // reset for two cycles, then the scenarios in order
    initial begin
        rst     = 1'b1;
        pinEn   = 1'b1;
        inDone  = '0;
        inOor   = '0;
        tDone   = '0;
        tUnder  = '0;
        tOver   = '0;
        remFail = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        testRegs();
        testRate();
        testCount();
        testHold();
        testPin();
        endSim();
    end
endmodule
